// file: rtl/ssfm_top.sv
// fault supervision of the back-emf standstill monitor
//
// Notes on behaviour
// [RQ1] open feedback loop reports fault with a group of four flashes
// [RQ2] channels disagreeing on threshold for 2.5 s continuously is a simultaneity failure
// [RQ3] simultaneity failure: fault output on, code five, output status lamp off
// [RQ4] simultaneity fault clears only after voltage rises above threshold then stops
// [RQ5] simultaneity clearing is automatic, fault reset input has no effect
// [RQ6] redundant setting readings must agree; mismatch gives code six or seven
// [RQ7] any fault keeps outputs de-energized and shows only one code
// [RQ8] below threshold starts standstill timer; outputs energize after the set delay
// [RQ9] undervoltage: outputs off, fault output on, one flash, automatic recovery
// [RQ10] wire breaks by priority: channel a or common first, then channel b
`include "ssfm_map.svh"

module ssfm_top #(
	parameter int unsigned TICK_CYCLES = `SSFM_TICK_CYCLES
) (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	// motor sense
	input  wire ssfm_pkg::ssfm_sense_t sense_i,
	// redundant setting readings
	input  wire ssfm_pkg::ssfm_setting_t setting_a_i,
	input  wire ssfm_pkg::ssfm_setting_t setting_b_i,
	// supply and feedback
	input  wire logic                  supply_ok_i,
	input  wire logic                  feedback_loop_closed_i,
	input  wire logic                  fault_reset_input_i,
	// outputs
	output logic                       safety_out_o,
	output logic                       fault_output_o,
	output logic                       fault_lamp_o,
	output logic                       output_status_lamp_o,
	output logic                       supply_lamp_o,
	output ssfm_pkg::ssfm_code_t       fault_code_o
);

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	logic [31:0] pre_ff, nxt_pre;
	logic        tick_ff, nxt_tick;

	always_comb begin
		nxt_tick = 1'b0;
		nxt_pre  = pre_ff + 32'h1;
		if (pre_ff >= TICK_CYCLES - 1) begin
			nxt_pre  = 32'h0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pre_ff  <= 32'h0;
			tick_ff <= 1'b0;
		end else begin
			pre_ff  <= nxt_pre;
			tick_ff <= nxt_tick;
		end
	end

	// ----------------------------------------------------------------
	// simultaneity supervision
	// ----------------------------------------------------------------
	ssfm_pkg::ssfm_sim_state_t     sim_ff, nxt_sim;
	logic [`SSFM_SIM_CNT_W-1:0]    sim_cnt_ff, nxt_sim_cnt;
	logic                          mismatch;
	logic                          both_above;
	logic                          both_below;

	assign mismatch   = sense_i.above_a ^ sense_i.above_b;
	assign both_above = sense_i.above_a & sense_i.above_b;
	assign both_below = ~sense_i.above_a & ~sense_i.above_b;

	// fault_reset_input_i is deliberately not consulted here
	always_comb begin
		nxt_sim     = sim_ff;
		nxt_sim_cnt = sim_cnt_ff;
		case (sim_ff)
			ssfm_pkg::SSFM_SIM_OK: begin
				if (!mismatch) begin
					nxt_sim_cnt = `SSFM_SIM_CNT_RST; // [RQ2]
				end else if (tick_ff) begin
					nxt_sim_cnt = sim_cnt_ff + 5'h1;
					if (nxt_sim_cnt >= `SSFM_SIM_CNT_W'(`SSFM_SIMUL_TICKS)) begin
						nxt_sim = ssfm_pkg::SSFM_SIM_FAULT; // [RQ2]
					end
				end
			end
			ssfm_pkg::SSFM_SIM_FAULT: begin
				nxt_sim_cnt = `SSFM_SIM_CNT_RST;
				if (both_above) begin
					nxt_sim = ssfm_pkg::SSFM_SIM_RUN; // [RQ4]
				end
			end
			ssfm_pkg::SSFM_SIM_RUN: begin
				if (both_below) begin
					nxt_sim = ssfm_pkg::SSFM_SIM_OK; // [RQ4] [RQ5]
				end
			end
			default: nxt_sim = ssfm_pkg::SSFM_SIM_OK;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sim_ff     <= ssfm_pkg::SSFM_SIM_OK;
			sim_cnt_ff <= `SSFM_SIM_CNT_RST;
		end else begin
			sim_ff     <= nxt_sim;
			sim_cnt_ff <= nxt_sim_cnt;
		end
	end

	// ----------------------------------------------------------------
	// standstill delay timer
	// ----------------------------------------------------------------
	logic [`SSFM_DLY_W-1:0] dly_cnt_ff, nxt_dly_cnt;
	logic [`SSFM_DLY_W-1:0] delay_ticks;
	logic                   still_ff, nxt_still;

	// settings below the minimum delay are raised to it
	assign delay_ticks = (setting_a_i.standstill_delay_setting < `SSFM_DELAY_MIN) ?
		`SSFM_DELAY_MIN : setting_a_i.standstill_delay_setting;

	always_comb begin
		nxt_dly_cnt = dly_cnt_ff;
		nxt_still   = still_ff;
		if (!both_below) begin
			nxt_dly_cnt = `SSFM_DLY_CNT_RST; // [RQ8]
			nxt_still   = 1'b0;
		end else if (tick_ff && !still_ff) begin
			nxt_dly_cnt = dly_cnt_ff + 6'h01;
			if (nxt_dly_cnt >= delay_ticks) begin
				nxt_still = 1'b1; // [RQ8]
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dly_cnt_ff <= `SSFM_DLY_CNT_RST;
			still_ff   <= 1'b0;
		end else begin
			dly_cnt_ff <= nxt_dly_cnt;
			still_ff   <= nxt_still;
		end
	end

	// ----------------------------------------------------------------
	// fault selection and outputs
	// ----------------------------------------------------------------
	ssfm_pkg::ssfm_code_t code_ff, nxt_code;
	logic                 safety_ff, nxt_safety;
	logic                 fault_ff, nxt_fault;
	logic                 status_ff, nxt_status;
	logic                 supply_ff, nxt_supply;

	// one code only: the highest-priority fault wins
	always_comb begin
		if (!supply_ok_i) begin
			nxt_code = ssfm_pkg::SSFM_CODE_UNDERV; // [RQ9]
		end else if (sense_i.break_a || sense_i.break_common) begin
			nxt_code = ssfm_pkg::SSFM_CODE_BREAK_A; // [RQ10]
		end else if (sense_i.break_b) begin
			nxt_code = ssfm_pkg::SSFM_CODE_BREAK_B; // [RQ10]
		end else if (!feedback_loop_closed_i) begin
			nxt_code = ssfm_pkg::SSFM_CODE_FEEDBACK; // [RQ1]
		end else if (sim_ff != ssfm_pkg::SSFM_SIM_OK) begin
			nxt_code = ssfm_pkg::SSFM_CODE_SIMUL; // [RQ3]
		end else if (setting_a_i.trip_voltage_threshold !=
				setting_b_i.trip_voltage_threshold) begin
			nxt_code = ssfm_pkg::SSFM_CODE_THR_MIS; // [RQ6]
		end else if (setting_a_i.standstill_delay_setting !=
				setting_b_i.standstill_delay_setting) begin
			nxt_code = ssfm_pkg::SSFM_CODE_DLY_MIS; // [RQ6]
		end else begin
			nxt_code = ssfm_pkg::SSFM_CODE_NONE;
		end
		nxt_fault  = (nxt_code != ssfm_pkg::SSFM_CODE_NONE); // [RQ3] [RQ6] [RQ9]
		nxt_safety = still_ff && !nxt_fault; // [RQ7] [RQ8]
		nxt_status = nxt_safety; // [RQ3]
		nxt_supply = supply_ok_i;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			code_ff   <= ssfm_pkg::SSFM_CODE_NONE;
			safety_ff <= 1'b0;
			fault_ff  <= 1'b0;
			status_ff <= 1'b0;
			supply_ff <= 1'b0;
		end else begin
			code_ff   <= nxt_code;
			safety_ff <= nxt_safety;
			fault_ff  <= nxt_fault;
			status_ff <= nxt_status;
			supply_ff <= nxt_supply;
		end
	end

	// ----------------------------------------------------------------
	// fault indicator
	// ----------------------------------------------------------------
	ssfm_blink u_ssfm_blink (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.tick_i    (tick_ff),
		.code_i    (code_ff), // [RQ1] [RQ7]
		.lamp_o    (fault_lamp_o)
	);

	assign safety_out_o         = safety_ff;
	assign fault_output_o       = fault_ff;
	assign output_status_lamp_o = status_ff;
	assign supply_lamp_o        = supply_ff;
	assign fault_code_o         = code_ff;

endmodule

// file: shared/ssfm_map.svh
// constants of the standstill fault monitor: timing counts, field widths and reset values
`ifndef SSFM_MAP_SVH
`define SSFM_MAP_SVH

// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define SSFM_CLK_HZ         25000000
`define SSFM_TICK_MS        100
`define SSFM_TICK_CYCLES    ((`SSFM_CLK_HZ / 1000) * `SSFM_TICK_MS)

// ----------------------------------------------------------------
// timing in milliseconds and ticks
// ----------------------------------------------------------------
`define SSFM_SIMUL_MS       2500
`define SSFM_SIMUL_TICKS    (`SSFM_SIMUL_MS / `SSFM_TICK_MS)
`define SSFM_DELAY_MIN      6'h02
`define SSFM_FLASH_ON_TICKS  4'h3
`define SSFM_FLASH_OFF_TICKS 4'h3
`define SSFM_PAUSE_TICKS    4'hA

// ----------------------------------------------------------------
// field widths and reset values
// ----------------------------------------------------------------
`define SSFM_THR_W          4
`define SSFM_DLY_W          6
`define SSFM_SIM_CNT_W      5
`define SSFM_SIM_CNT_RST    5'h00
`define SSFM_DLY_CNT_RST    6'h00

`endif

// file: shared/ssfm_pkg.sv
// types of the standstill fault monitor
`include "ssfm_map.svh"

package ssfm_pkg;

	// one redundant reading of the two front-panel settings
	typedef struct packed {
		logic [`SSFM_THR_W-1:0] trip_voltage_threshold;
		logic [`SSFM_DLY_W-1:0] standstill_delay_setting;
	} ssfm_setting_t;

	// comparator results and wire checks of the sense inputs
	typedef struct packed {
		logic above_a;
		logic above_b;
		logic break_common;
		logic break_a;
		logic break_b;
	} ssfm_sense_t;

	// blink codes, lower value has priority
	typedef enum logic [2:0] {
		SSFM_CODE_NONE     = 3'h0,
		SSFM_CODE_UNDERV   = 3'h1,
		SSFM_CODE_BREAK_A  = 3'h2,
		SSFM_CODE_BREAK_B  = 3'h3,
		SSFM_CODE_FEEDBACK = 3'h4,
		SSFM_CODE_SIMUL    = 3'h5,
		SSFM_CODE_THR_MIS  = 3'h6,
		SSFM_CODE_DLY_MIS  = 3'h7
	} ssfm_code_t;

	typedef enum logic [1:0] {
		SSFM_SIM_OK    = 2'h0,
		SSFM_SIM_FAULT = 2'h1,
		SSFM_SIM_RUN   = 2'h3
	} ssfm_sim_state_t;

	typedef enum logic [1:0] {
		SSFM_BL_IDLE  = 2'h0,
		SSFM_BL_ON    = 2'h1,
		SSFM_BL_OFF   = 2'h3,
		SSFM_BL_PAUSE = 2'h2
	} ssfm_blink_state_t;

endpackage

// file: rtl/ssfm_blink.sv
// blink-code generator for the fault indicator
`include "ssfm_map.svh"

module ssfm_blink (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	// time base and code
	input  wire logic               tick_i,
	input  wire ssfm_pkg::ssfm_code_t code_i,
	// lamp
	output logic                    lamp_o
);

	ssfm_pkg::ssfm_blink_state_t state_ff, nxt_state;
	ssfm_pkg::ssfm_code_t        code_ff,  nxt_code;
	logic [3:0]                  time_ff,  nxt_time;
	logic [2:0]                  count_ff, nxt_count;
	logic                        lamp_ff,  nxt_lamp;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// code is latched per group so a changing fault never truncates a group
	always_comb begin
		nxt_state = state_ff;
		nxt_code  = code_ff;
		nxt_time  = time_ff;
		nxt_count = count_ff;
		case (state_ff)
			ssfm_pkg::SSFM_BL_IDLE: begin
				if (code_i != ssfm_pkg::SSFM_CODE_NONE) begin
					nxt_state = ssfm_pkg::SSFM_BL_ON;
					nxt_code  = code_i;
					nxt_count = 3'h1;
					nxt_time  = 4'h0;
				end
			end
			ssfm_pkg::SSFM_BL_ON: begin
				if (tick_i) begin
					nxt_time = time_ff + 4'h1;
					if (nxt_time >= `SSFM_FLASH_ON_TICKS) begin
						nxt_state = ssfm_pkg::SSFM_BL_OFF;
						nxt_time  = 4'h0;
					end
				end
			end
			ssfm_pkg::SSFM_BL_OFF: begin
				if (tick_i) begin
					nxt_time = time_ff + 4'h1;
					if (nxt_time >= `SSFM_FLASH_OFF_TICKS) begin
						nxt_time = 4'h0;
						if (count_ff == code_ff) begin
							nxt_state = ssfm_pkg::SSFM_BL_PAUSE;
						end else begin
							nxt_state = ssfm_pkg::SSFM_BL_ON;
							nxt_count = count_ff + 3'h1;
						end
					end
				end
			end
			ssfm_pkg::SSFM_BL_PAUSE: begin
				if (tick_i) begin
					nxt_time = time_ff + 4'h1;
					if (nxt_time >= `SSFM_PAUSE_TICKS) begin
						nxt_state = ssfm_pkg::SSFM_BL_IDLE;
						nxt_time  = 4'h0;
					end
				end
			end
			default: nxt_state = ssfm_pkg::SSFM_BL_IDLE;
		endcase
		nxt_lamp = (nxt_state == ssfm_pkg::SSFM_BL_ON);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= ssfm_pkg::SSFM_BL_IDLE;
			code_ff  <= ssfm_pkg::SSFM_CODE_NONE;
			time_ff  <= 4'h0;
			count_ff <= 3'h0;
			lamp_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			code_ff  <= nxt_code;
			time_ff  <= nxt_time;
			count_ff <= nxt_count;
			lamp_ff  <= nxt_lamp;
		end
	end

	assign lamp_o = lamp_ff;

endmodule

// file: testbench/ssfm_top_properties.sv
// checker of the standstill fault monitor ports
module ssfm_top_properties #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic                    clk_i,
	input wire logic                    reset_n_i,
	input wire ssfm_pkg::ssfm_sense_t   sense_i,
	input wire ssfm_pkg::ssfm_setting_t setting_a_i,
	input wire ssfm_pkg::ssfm_setting_t setting_b_i,
	input wire logic                    supply_ok_i,
	input wire logic                    feedback_loop_closed_i,
	input wire logic                    safety_out_o,
	input wire logic                    fault_output_o,
	input wire logic                    output_status_lamp_o,
	input wire ssfm_pkg::ssfm_code_t    fault_code_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// helper counts of input conditions
	// ----------------------------------------
	int  mis_ff;
	int  low_ff;
	int  need;
	wire ok = supply_ok_i && !sense_i.break_common && !sense_i.break_a;
	wire bl = !sense_i.above_a && !sense_i.above_b;
	assign need = ((setting_a_i.standstill_delay_setting < 6'h02) ? 2
		: int'(setting_a_i.standstill_delay_setting)) - 1;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mis_ff <= 0;
			low_ff <= 0;
		end else begin
			mis_ff <= (sense_i.above_a != sense_i.above_b) ? mis_ff + 1 : 0;
			low_ff <= bl ? low_ff + 1 : 0;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_status_follow: assert property (output_status_lamp_o == safety_out_o)
		else $error("status lamp differs from safety output");
	chk_fault_blocks: assert property (fault_output_o |-> !safety_out_o)
		else $error("safety output high during fault");
	chk_one_code: assert property ((fault_code_o != 3'h0) == fault_output_o)
		else $error("fault output and code disagree");
	chk_underv_code: assert property (!supply_ok_i |=> fault_code_o == 3'h1)
		else $error("undervoltage code missing");
	chk_break_first: assert property (supply_ok_i &&
		(sense_i.break_common || sense_i.break_a) |=> fault_code_o == 3'h2)
		else $error("first channel break not reported");
	chk_break_second: assert property (ok && sense_i.break_b |=> fault_code_o == 3'h3)
		else $error("second channel break not reported");
	chk_feedback_code: assert property (ok && !sense_i.break_b &&
		!feedback_loop_closed_i |=> fault_code_o == 3'h4)
		else $error("open feedback loop not reported");
	chk_setting_fault: assert property (setting_a_i != setting_b_i |=> fault_output_o)
		else $error("setting mismatch without fault");
	chk_simul_time: assert property ($rose(fault_code_o == 3'h5) |-> $past(mis_ff, 3) >= 90)
		else $error("simultaneity fault too early");
	chk_simul_hold: assert property ((fault_code_o == 3'h5 && bl)[*3] |=> fault_output_o)
		else $error("simultaneity fault cleared without rise");
	chk_delay_min: assert property ($rose(safety_out_o) |-> low_ff >= need * TICK_CYCLES)
		else $error("safety output before standstill delay");
	cov_simul: cover property (fault_code_o == 3'h5);
	cov_feedback: cover property (fault_code_o == 3'h4);
	cov_energized: cover property ($rose(safety_out_o));
endmodule

// file: testbench/ssfm_motor_model.sv
// motor winding and feedback contact model
module ssfm_motor_model (
	input  wire logic            clk_i,
	input  wire logic            run_a_i,
	input  wire logic            run_b_i,
	input  wire logic [2:0]      brk_i,
	input  wire logic            loop_open_i,
	output ssfm_pkg::ssfm_sense_t sense_o,
	output logic                 loop_closed_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// windings settle one clock after the command changes
	initial sense_o = '0;
	initial loop_closed_o = 1'b1;
	// plain always: the initial blocks above also write these variables
	always @(posedge clk_i) begin
		sense_o <= {run_a_i, run_b_i, brk_i};
		loop_closed_o <= !loop_open_i;
	end
endmodule

// file: testbench/test_standstill_fault_monitor.sv
// self-checking bench of the standstill fault monitor
module test_standstill_fault_monitor;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, reset_n_i = 0, supply_ok_i = 1, rst_in = 0;
	logic run_a = 0, run_b = 0, loop_open = 0, fb, safety, fault, lamp, status, sup;
	logic [2:0] brk = 3'h0;
	ssfm_pkg::ssfm_sense_t sense;
	ssfm_pkg::ssfm_setting_t set_a = {4'h5, 6'h03}, set_b = {4'h5, 6'h03};
	ssfm_pkg::ssfm_code_t code;
	int miscompares = 0, n_tests = 0, cycles = 0;
	initial forever #20 clk_i = ~clk_i;
	ssfm_motor_model u_ssfm_motor_model (.clk_i(clk_i), .run_a_i(run_a), .run_b_i(run_b),
		.brk_i(brk), .loop_open_i(loop_open), .sense_o(sense), .loop_closed_o(fb));
	ssfm_top #(.TICK_CYCLES(4)) u_ssfm_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.sense_i(sense), .setting_a_i(set_a), .setting_b_i(set_b),
		.supply_ok_i(supply_ok_i), .feedback_loop_closed_i(fb),
		.fault_reset_input_i(rst_in), .safety_out_o(safety), .fault_output_o(fault),
		.fault_lamp_o(lamp), .output_status_lamp_o(status), .supply_lamp_o(sup),
		.fault_code_o(code));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task give_verdict;
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask
	// counts the flashes of one group; the window stops before the next group
	task flashes(input int exp);
		int low;
		int rises;
		logic prev;
		low = 0;
		for (int i = 0; i < 400 && low < 20; i++) begin
			cyc(1);
			low = (lamp === 1'b1) ? 0 : low + 1;
		end
		for (int i = 0; i < 60 && lamp !== 1'b1; i++) cyc(1);
		rises = (lamp === 1'b1) ? 1 : 0;
		prev = lamp;
		repeat (((exp - 1) * 6 + 3) * 4) begin
			cyc(1);
			if (lamp === 1'b1 && prev !== 1'b1) rises++;
			prev = lamp;
		end
		chk(rises, exp);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_standstill;
		cyc(8);
		chk({safety, fault, code}, 8'h00);
		reset_n_i = 1;
		cyc(8);
		chk(safety, 0);
		cyc(9);
		chk({safety, status, code}, 8'h18);
	endtask
	task t_underv;
		supply_ok_i = 0;
		rst_in = 1;
		cyc(2);
		chk({safety, fault, sup, code}, 8'h11);
		flashes(1);
		supply_ok_i = 1;
		cyc(3);
		chk({safety, fault, code}, 8'h10);
		rst_in = 0;
	endtask
	task t_breaks;
		logic [2:0] tab [3] = '{3'h3, 3'h4, 3'h1};
		logic [2:0] exp [3] = '{3'h2, 3'h2, 3'h3};
		for (int i = 0; i < 3; i++) begin
			brk = tab[i];
			cyc(3);
			chk({safety, code}, {5'h0, exp[i]});
		end
		flashes(3);
		brk = 3'h0;
		cyc(3);
		chk(code, 8'h0);
	endtask
	task t_feedback;
		loop_open = 1;
		cyc(3);
		chk({safety, code}, 8'h04);
		flashes(4);
		loop_open = 0;
		cyc(3);
		chk(code, 8'h0);
	endtask
	task t_settings;
		set_b.trip_voltage_threshold = 4'h6;
		cyc(3);
		chk({fault, code}, 8'h0E);
		flashes(6);
		set_b = {4'h5, 6'h04};
		cyc(3);
		chk({fault, code}, 8'h0F);
		flashes(7);
		set_b = set_a;
		cyc(3);
		chk(fault, 0);
	endtask
	task t_simul;
		run_a = 1;
		cyc(88);
		run_a = 0;
		cyc(20);
		chk(code, 8'h0);
		run_a = 1;
		cyc(110);
		chk({status, fault, code}, 8'h0D);
		flashes(5);
		run_a = 0;
		rst_in = 1;
		cyc(30);
		chk(code, 8'h5);
		run_a = 1;
		run_b = 1;
		cyc(6);
		run_a = 0;
		run_b = 0;
		cyc(6);
		chk(code, 8'h0);
		cyc(20);
		chk(safety, 1);
	endtask
	// ----------------------------------------
	// main sequence and time limit
	// ----------------------------------------
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end
	initial begin
		t_standstill();
		t_underv();
		t_breaks();
		t_feedback();
		t_settings();
		t_simul();
		give_verdict();
	end
endmodule
bind ssfm_top ssfm_top_properties #(.TICK_CYCLES(TICK_CYCLES)) u_ssfm_top_properties (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .sense_i(sense_i), .setting_a_i(setting_a_i),
	.setting_b_i(setting_b_i), .supply_ok_i(supply_ok_i),
	.feedback_loop_closed_i(feedback_loop_closed_i), .safety_out_o(safety_out_o),
	.fault_output_o(fault_output_o), .output_status_lamp_o(output_status_lamp_o),
	.fault_code_o(fault_code_o));
